// ==== ivp_chk.sv ====
// Purpose: Concurrent checks on the vector, break and reset outputs.
// Assumes: Bound to ivp_core from the testbench top file.
// Notes:   One clock domain, so default clocking and disable are used.
module ivp_chk
   import ivp_pkg::*;
(
   input wire logic                       clk_sys_i,
   input wire logic                       resetn_i,
   input wire logic [ivp_pkg::NSRC-1:0]   irq_req_i,
   input wire logic                       voltage_detect_event_i,
   input wire logic [7:0]                 voltage_detect_level_reg_i,
   input wire logic                       break_instruction_i,
   input wire logic                       opcode_valid_i,
   input wire logic [7:0]                 opcode_i,
   input wire logic                       debug_issue_i,
   input wire logic                       power_on_reset_i,
   input wire logic                       cpu_ack_i,
   input wire logic                       irq_valid_o,
   input wire logic [ivp_pkg::VEC_W-1:0]  irq_vector_o,
   input wire logic [ivp_pkg::RANK_W-1:0] irq_rank_o,
   input wire logic                       break_take_o,
   input wire logic [ivp_pkg::VEC_W-1:0]  break_vector_o,
   input wire logic                       reset_req_o,
   input wire logic [ivp_pkg::VEC_W-1:0]  reset_vector_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_taken;
      irq_valid_o && cpu_ack_i;
   endsequence
   sequence s_trap;
      opcode_valid_i && opcode_i == 8'hFF && !debug_issue_i;
   endsequence
   a_break_vec: assert property (break_vector_o == 20'h0_007E)
      else $error("break vector wrong");
   a_break_take: assert property (break_instruction_i |=> break_take_o)
      else $error("break not taken");
   a_reset_vec: assert property (reset_vector_o == 20'h0_0000)
      else $error("reset vector wrong");
   a_vec_map: assert property (irq_valid_o |-> irq_vector_o == 20'h0_0004 + {irq_rank_o, 1'b0})
      else $error("vector does not match rank");
   a_valid_lat: assert property ($rose(irq_valid_o) |-> $past(|irq_req_i || voltage_detect_event_i, 9))
      else $error("interrupt offered too early");
   a_ack_drop: assert property (s_taken |=> !irq_valid_o)
      else $error("valid held after ack");
   a_por_reset: assert property (power_on_reset_i |=> reset_req_o)
      else $error("power on without reset");
   a_trap_reset: assert property (s_trap |=> reset_req_o)
      else $error("illegal opcode without reset");
   a_vdet_reset: assert property (voltage_detect_event_i && voltage_detect_level_reg_i[7] |=> reset_req_o)
      else $error("voltage event without reset");
endmodule // ivp_chk

// ==== ivp_core.sv ====
// Purpose: Ranks maskable requests, gives vector addresses for interrupts,
//          the software break and every reset source.
// Assumes: Request, mask and level flags are held outside; levels 0 is highest.
// Notes:   One vector is offered at a time; the CPU acknowledges it.
// How it works
// - Timer ch0 rank 20 vector 2C; timer ch1 rank 21 vector 2E.
// - Serial 3 transmit events, all modes, rank 28 vector 3C.
// - Converter done request at rank 24, vector 34.
// - Calendar clock event at rank 25, vector 36.
// - Interval timer event at rank 26, vector 38.
// - Key return event at rank 27, vector 3A.
// - Timer channels 4 to 7 at ranks 31 to 34, vectors 42 upward.
// - Serial 3 receive error and timer 13 upper share rank 44, vector 5C.
// - Divide done or multiply-accumulate overflow at rank 45, vector 5E.
// - Second two-wire controller done at rank 46, vector 60.
// - Rank 47, vector 62, kept for flash library use only.
// - DMA channels 2 and 3 at ranks 48 and 49, vectors 64 and 66.
// - Timer channels 14 to 17 at ranks 50 to 53, last vector 6E.
// - Break instruction vectors to 7E regardless of enable or priority.
// - Power-on, voltage, watchdog, illegal access and parity errors reset.
// - Opcode FF resets unless issued by the debug emulator.
// - Voltage detection resets when the select bit 7 is one.
// - With select bit zero, voltage detection requests rank 1, vector 06.
// - Watchdog interval at rank 0, vector 04, when option bit enables it.
// - From idle, the vector is offered a fixed 10 clocks after the request.
module ivp_core
   import ivp_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   input  wire logic [ivp_pkg::NSRC-1:0] irq_req_i,
   input  wire logic [ivp_pkg::NSRC-1:0] irq_mask_i,
   input  wire logic [2*ivp_pkg::NSRC-1:0] irq_level_i,
   input  wire logic [2:0]              isr_level_i,
   input  wire logic                    int_enable_i,
   input  wire logic                    watchdog_interval_enable_i,
   input  wire logic                    voltage_detect_event_i,
   input  wire logic [7:0]              voltage_detect_level_reg_i,
   input  wire logic                    break_instruction_i,
   input  wire logic                    opcode_valid_i,
   input  wire logic [7:0]              opcode_i,
   input  wire logic                    debug_issue_i,
   input  wire logic                    reset_pin_n_i,
   input  wire logic                    power_on_reset_i,
   input  wire logic                    watchdog_overflow_i,
   input  wire logic                    illegal_access_reset_i,
   input  wire logic                    ram_parity_reset_i,
   input  wire logic                    cpu_ack_i,
   output logic                         irq_valid_o,
   output logic [ivp_pkg::VEC_W-1:0]    irq_vector_o,
   output logic [ivp_pkg::RANK_W-1:0]   irq_rank_o,
   output logic [1:0]                   irq_level_o,
   output logic                         break_take_o,
   output logic [ivp_pkg::VEC_W-1:0]    break_vector_o,
   output logic                         reset_req_o,
   output logic [ivp_pkg::VEC_W-1:0]    reset_vector_o,
   output logic [2:0]                   reset_cause_o
);
   import ivp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Rank to vector: two bytes per rank from the first maskable entry.

   function automatic logic [VEC_W-1:0] rank_vec(input logic [RANK_W-1:0] r);
      rank_vec = VEC_RANK0 + {13'h0_000, r, 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser, two flops, for the asynchronous reset pin only.

   logic [1:0] pin_sync_q;
   logic [1:0] pin_sync_d;

   always_comb begin
      pin_sync_d = {pin_sync_q[0], reset_pin_n_i};
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         pin_sync_q <= 2'b11;
      end else begin
         pin_sync_q <= pin_sync_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective request lines; the voltage and watchdog entries are steered here.

   logic                vdet_resets;
   logic [NSRC-1:0]     eff_req;

   always_comb begin
      vdet_resets = voltage_detect_level_reg_i[VDET_SEL_BIT];
      eff_req     = irq_req_i;
      eff_req[RANK_WDT_IVL] = irq_req_i[RANK_WDT_IVL] &
                              watchdog_interval_enable_i;
      eff_req[RANK_VDET]    = (irq_req_i[RANK_VDET] | voltage_detect_event_i) &
                              ~vdet_resets;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority resolution: lowest level wins, lowest rank breaks ties.
   // Shared entries (ranks 28, 44, 45) are the OR of their sources outside.
   // Ranks 20, 21, 24-28, 31-34, 44-53 follow the table by rank order.

   logic              win_found;
   logic [RANK_W-1:0] win_rank;
   logic [1:0]        win_lvl;
   logic [1:0]        lvl;

   always_comb begin
      win_found = 1'b0;
      win_rank  = '0;
      win_lvl   = 2'b11;
      lvl       = 2'b00;
      for (int i = 0; i < NSRC; i++) begin
         lvl = irq_level_i[2*i +: 2];
         if (int_enable_i && eff_req[i] && !irq_mask_i[i] &&
             ({1'b0, lvl} < isr_level_i)) begin
            if (!win_found || (lvl < win_lvl)) begin
               win_found = 1'b1;
               win_rank  = RANK_W'(i);
               win_lvl   = lvl;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Service timing: from idle, a request is offered a fixed 10 clocks later.

   ivp_state_t        st_q;
   ivp_state_t        st_d;
   logic [3:0]        lat_q;
   logic [3:0]        lat_d;
   logic [RANK_W-1:0] rank_q;
   logic [RANK_W-1:0] rank_d;
   logic [1:0]        lvl_q;
   logic [1:0]        lvl_d;

   always_comb begin
      st_d   = st_q;
      lat_d  = lat_q;
      rank_d = rank_q;
      lvl_d  = lvl_q;
      unique case (st_q)
         IVP_IDLE: begin
            if (win_found) begin
               st_d  = IVP_WAIT;
               lat_d = LAT_CNT_RST;
            end
         end
         IVP_WAIT: begin
            lat_d = lat_q + 4'h1;
            if (!win_found) begin
               st_d = IVP_IDLE;
            end else if (lat_q == LAT_START) begin
               st_d   = IVP_ACK;
               rank_d = win_rank;
               lvl_d  = win_lvl;
            end
         end
         IVP_ACK: begin
            if (cpu_ack_i || !win_found) begin
               st_d = IVP_IDLE;
            end else begin
               rank_d = win_rank;
               lvl_d  = win_lvl;
            end
         end
         default: begin
            st_d = IVP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         st_q   <= IVP_IDLE;
         lat_q  <= LAT_CNT_RST;
         rank_q <= '0;
         lvl_q  <= 2'b00;
      end else begin
         st_q   <= st_d;
         lat_q  <= lat_d;
         rank_q <= rank_d;
         lvl_q  <= lvl_d;
      end
   end

   always_comb begin
      irq_valid_o  = (st_q == IVP_ACK);
      irq_rank_o   = rank_q;
      irq_level_o  = lvl_q;
      irq_vector_o = rank_vec(rank_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software break: ignores enable, mask and level.

   logic brk_q;
   logic brk_d;

   always_comb begin
      brk_d = break_instruction_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         brk_q <= 1'b0;
      end else begin
         brk_q <= brk_d;
      end
   end

   always_comb begin
      break_take_o   = brk_q;
      break_vector_o = VEC_BREAK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset sources, all through the common vector.

   logic       rst_q;
   logic       rst_d;
   logic [2:0] cause_q;
   logic [2:0] cause_d;
   logic       trap;

   always_comb begin
      trap    = opcode_valid_i && (opcode_i == OPC_ILLEGAL) &&
                !debug_issue_i;
      rst_d   = 1'b1;
      cause_d = 3'h0;
      if (!pin_sync_q[1]) begin
         cause_d = 3'h1;
      end else if (power_on_reset_i) begin
         cause_d = 3'h2;
      end else if (voltage_detect_event_i && vdet_resets) begin
         cause_d = 3'h3;
      end else if (watchdog_overflow_i) begin
         cause_d = 3'h4;
      end else if (trap) begin
         cause_d = 3'h5;
      end else if (illegal_access_reset_i) begin
         cause_d = 3'h6;
      end else if (ram_parity_reset_i) begin
         cause_d = 3'h7;
      end else begin
         rst_d   = 1'b0;
         cause_d = cause_q;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         rst_q   <= 1'b0;
         cause_q <= 3'h0;
      end else begin
         rst_q   <= rst_d;
         cause_q <= cause_d;
      end
   end

   always_comb begin
      reset_req_o    = rst_q;
      reset_cause_o  = cause_q;
      reset_vector_o = VEC_RESET;
   end

endmodule // ivp_core

// ==== ivp_cpu_model.sv ====
// Purpose: CPU side that takes an offered vector after a set delay.
// Assumes: One acknowledge pulse per offer.
// Notes:   Delay 0 answers on the next clock, larger values stall the offer.
module ivp_cpu_model (
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic       irq_valid_i,
   input  wire logic [3:0] delay_i,
   output logic            cpu_ack_o
);
   logic [3:0] cnt_q, cnt_d;
   logic       ack_q, ack_d;
   assign cpu_ack_o = ack_q;
   always_comb begin
      cnt_d = 4'h0;
      ack_d = 1'b0;
      if (irq_valid_i && !ack_q) begin
         ack_d = (cnt_q == delay_i);
         cnt_d = cnt_q + 4'h1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ack_q <= ack_d;
      end
   end
endmodule // ivp_cpu_model

// ==== ivp_pkg.sv ====
// Purpose: Constants shared by the interrupt vector and priority logic.
// Assumes: Ranks 0 to 53 are the maskable sources in default order.
// Notes:   Vector addresses are 20-bit byte addresses of two-byte entries.
package ivp_pkg;
   localparam int unsigned NSRC           = 54;
   localparam int unsigned RANK_W         = 6;
   localparam int unsigned VEC_W          = 20;
   localparam logic [19:0] VEC_RESET      = 20'h0_0000;
   localparam logic [19:0] VEC_RANK0      = 20'h0_0004;
   localparam logic [19:0] VEC_BREAK      = 20'h0_007E;
   localparam int unsigned RANK_WDT_IVL   = 0;
   localparam int unsigned RANK_VDET      = 1;
   localparam int unsigned RANK_TM0       = 20;
   localparam int unsigned RANK_TM1       = 21;
   localparam int unsigned RANK_ADC       = 24;
   localparam int unsigned RANK_RTC       = 25;
   localparam int unsigned RANK_ITMR      = 26;
   localparam int unsigned RANK_KEY       = 27;
   localparam int unsigned RANK_SER3_TX   = 28;
   localparam int unsigned RANK_TM4       = 31;
   localparam int unsigned RANK_SER3_ERR  = 44;
   localparam int unsigned RANK_MULDIV    = 45;
   localparam int unsigned RANK_TW1       = 46;
   localparam int unsigned RANK_FLASH     = 47;
   localparam int unsigned RANK_DMA2      = 48;
   localparam int unsigned RANK_DMA3      = 49;
   localparam int unsigned RANK_TM14      = 50;
   localparam int unsigned VDET_SEL_BIT   = 7;
   localparam logic [7:0]  OPC_ILLEGAL    = 8'hFF;
   localparam int unsigned LAT_MIN_CLK    = 9;
   localparam int unsigned LAT_MAX_CLK    = 16;
   localparam logic [3:0]  LAT_CNT_RST    = 4'h0;
   localparam logic [3:0]  LAT_START      = 4'(LAT_MIN_CLK - 1);
   typedef enum logic [2:0] {
      IVP_IDLE = 3'b001,
      IVP_WAIT = 3'b010,
      IVP_ACK  = 3'b100
   } ivp_state_t;
endpackage : ivp_pkg

// ==== tb.sv ====
// Purpose: Self-checking bench for the vector and priority logic.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   The CPU model acknowledges with a varied delay.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ivp_pkg::*;
   logic clk_sys_i = 0, resetn_i = 0, ien = 1, wen = 0, break_instruction = 0, dbg = 0, pin_n = 1;
   logic [53:0] req = '0, mask = '0;
   logic [107:0] lvl = '1;
   logic [2:0] isr = 3'h4, cause;
   logic [5:0] rsrc = '0, rank;
   logic [7:0] lreg = 8'h80, opc = 8'hFF;
   logic [3:0] dly = 4'h0;
   logic [19:0] vec, bvec, rvec;
   logic [1:0] olvl;
   logic valid, btake, rreq, ack;
   int errors = 0, check_count = 0;
   ivp_core ivp_core_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .irq_req_i(req),
      .irq_mask_i(mask), .irq_level_i(lvl), .isr_level_i(isr), .int_enable_i(ien),
      .watchdog_interval_enable_i(wen), .voltage_detect_event_i(rsrc[1]),
      .voltage_detect_level_reg_i(lreg), .break_instruction_i(break_instruction),
      .opcode_valid_i(rsrc[3]), .opcode_i(opc), .debug_issue_i(dbg), .reset_pin_n_i(pin_n),
      .power_on_reset_i(rsrc[0]), .watchdog_overflow_i(rsrc[2]),
      .illegal_access_reset_i(rsrc[4]), .ram_parity_reset_i(rsrc[5]), .cpu_ack_i(ack),
      .irq_valid_o(valid), .irq_vector_o(vec), .irq_rank_o(rank), .irq_level_o(olvl),
      .break_take_o(btake), .break_vector_o(bvec), .reset_req_o(rreq),
      .reset_vector_o(rvec), .reset_cause_o(cause));
   ivp_cpu_model ivp_cpu_model_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .irq_valid_i(valid), .delay_i(dly), .cpu_ack_o(ack));
   ////////////////////////////////////////////////////////////////////////////////
   task step; @(posedge clk_sys_i); #1; endtask
   task chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task serve(input logic [53:0] r, input logic [19:0] e, input string nm);
      int n;
      req = r;
      for (n = 0; n < 40 && valid !== 1'b1; n++) step;
      chk(nm, e, vec);
      chk("latency", 20'h1, 20'(n >= 9 && n <= 16));
      for (int k = 0; k < 20 && ack !== 1'b1; k++) step;
      req = '0;
      repeat (3) step;
   endtask
   task none(input logic [53:0] r, input string nm);
      logic s;
      s = 1'b0;
      req = r;
      repeat (20) begin step; s = s | valid; end
      chk(nm, 20'h0, 20'(s));
      req = '0;
      step;
   endtask
   task t_table;
      int rk[19] = '{20, 21, 24, 25, 26, 27, 28, 31, 32, 33, 34, 44, 45, 46, 47, 48, 49, 50, 53};
      logic [19:0] ev[19] = '{20'h0_002C, 20'h0_002E, 20'h0_0034, 20'h0_0036, 20'h0_0038,
         20'h0_003A, 20'h0_003C, 20'h0_0042, 20'h0_0044, 20'h0_0046, 20'h0_0048, 20'h0_005C,
         20'h0_005E, 20'h0_0060, 20'h0_0062, 20'h0_0064, 20'h0_0066, 20'h0_0068, 20'h0_006E};
      for (int i = 0; i < 19; i++) begin
         dly = 4'(i % 4);
         serve(54'(1) << rk[i], ev[i], "table vector");
      end
      $display("t_table done");
   endtask
   task t_prio;
      logic [53:0] r;
      r = (54'(1) << 20) | (54'(1) << 28) | (54'(1) << 53);
      serve(r, 20'h0_002C, "tie winner");
      mask[20] = 1'b1;
      serve(r, 20'h0_003C, "masked skip");
      mask = '0;
      lvl[107:106] = 2'h0;
      serve(r, 20'h0_006E, "level winner");
      chk("winner rank", 20'd53, 20'(rank));
      chk("winner level", 20'h0, 20'(olvl));
      lvl = '1;
      isr = 3'h0;
      none(r, "level blocked");
      isr = 3'h4;
      none(54'(1), "rank0 gated");
      wen = 1'b1;
      serve(54'(1), 20'h0_0004, "rank0 vector");
      $display("t_prio done");
   endtask
   task t_break;
      ien = 1'b0;
      break_instruction = 1'b1;
      step;
      break_instruction = 1'b0;
      chk("break take", 20'h1, 20'(btake));
      chk("break vector", 20'h0_007E, bvec);
      ien = 1'b1;
      $display("t_break done");
   endtask
   task t_reset;
      for (int k = 0; k < 6; k++) begin
         rsrc = 6'(1) << k;
         step;
         rsrc = '0;
         chk("reset req", 20'h1, 20'(rreq));
         chk("reset cause", 20'(k + 2), 20'(cause));
         chk("reset vector", 20'h0_0000, rvec);
         step;
      end
      dbg = 1'b1;
      rsrc = 6'h08;
      step;
      rsrc = '0;
      dbg = 1'b0;
      chk("debug opcode", 20'h0, 20'(rreq));
      opc = 8'h00;
      rsrc = 6'h08;
      step;
      rsrc = '0;
      opc = 8'hFF;
      chk("legal opcode", 20'h0, 20'(rreq));
      lreg = 8'h00;
      rsrc = 6'h02;
      step;
      chk("volt no reset", 20'h0, 20'(rreq));
      serve('0, 20'h0_0006, "volt vector");
      rsrc = '0;
      lreg = 8'h80;
      pin_n = 1'b0;
      repeat (3) step;
      pin_n = 1'b1;
      for (int k = 0; k < 8 && rreq !== 1'b1; k++) step;
      chk("pin cause", 20'h1, 20'(cause));
      $display("t_reset done");
   endtask
   task end_sim;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #100000;
      errors++;
      end_sim;
   end
   initial begin
      repeat (8) step;
      resetn_i = 1'b1;
      step;
      t_table;
      t_prio;
      t_break;
      t_reset;
      end_sim;
   end
endmodule // tb
bind ivp_core ivp_chk ivp_chk_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
   .irq_req_i(irq_req_i), .voltage_detect_event_i(voltage_detect_event_i),
   .voltage_detect_level_reg_i(voltage_detect_level_reg_i),
   .break_instruction_i(break_instruction_i), .opcode_valid_i(opcode_valid_i),
   .opcode_i(opcode_i), .debug_issue_i(debug_issue_i), .power_on_reset_i(power_on_reset_i),
   .cpu_ack_i(cpu_ack_i), .irq_valid_o(irq_valid_o), .irq_vector_o(irq_vector_o),
   .irq_rank_o(irq_rank_o), .break_take_o(break_take_o), .break_vector_o(break_vector_o),
   .reset_req_o(reset_req_o), .reset_vector_o(reset_vector_o));
